// File: inc/ir_remote_regs.vh
// Register map, field positions, reset values and timing for the IR transmitter
// Overview of operation
// - Transmit output is carrier AND data waveform.
// - 8-bit carrier counter; carrier high from zero, toggles at duty match.
// - At period match carrier toggles and counter returns to zero.
// - Counter clear zeroes both counters; run starts and stops both counters.
// - 16-bit data counter; data active from zero, toggles at active match.
// - At data-length match data toggles and data counter returns to zero.
// - Repeat mode: data counter cycles until run is cleared.
// - One-shot mode: data counter stops itself at data-length match.
// - Shadows off: compare against registers, rewrite acts at once.
// - Shadows on: compare against shadow copies of both lengths.
// - Shadows reload from registers on shadowed data-length match.
// - Shadows on: busy flag set on write, cleared when copied.
// - Active match flag set on match; cleared by write one or soft reset.
// - Length match flag set on match; cleared by write one or soft reset.
// - Interrupt request only while an enabled flag is set.
// - Transmit and clear-pulse outputs act while run is one.
// - Debug keep bit lets operating clock run during debug halt.
// - Source and divider fields; divider k divides by two to the k, except source 3 (never divided) and k above 8 on source 1 (divides by one).
// - Soft reset forces counter clear and run to zero.
// - One-shot stop clears run automatically.
// - Soft reset clears counters and flags, reads one while busy, self-clears.
// - Module enable gates operating clock; disabled blocks length writes.
// - Writes to a length register are ignored while its busy flag is one.
`ifndef IR_REMOTE_REGS_VH
`define IR_REMOTE_REGS_VH
`define ADDR_CLK_CTRL 4'h0
`define ADDR_CNT_CTRL 4'h1
`define ADDR_BIT_COUNT 4'h2
`define ADDR_ACTIVE_LEN 4'h3
`define ADDR_BIT_LEN 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_INTEN 4'h6
`define ADDR_CARR 4'h7
`define ADDR_CCTL 4'h8
`define CLK_DBG_BIT 8
`define CLK_DIV_HI 7
`define CLK_DIV_LO 4
`define CLK_SRC_HI 1
`define CLK_SRC_LO 0
`define CC_CLR_BIT 9
`define CC_RUN_BIT 8
`define CC_INV_BIT 4
`define CC_BUF_BIT 3
`define CC_ONE_BIT 2
`define CC_SRST_BIT 1
`define CC_EN_BIT 0
`define ST_RUN_BIT 10
`define ST_DBBSY_BIT 9
`define ST_APBSY_BIT 8
`define ST_DBF_BIT 1
`define ST_APF_BIT 0
`define CCTL_OINV_BIT 8
`define CCTL_CAR_BIT 0
`define RESET_VAL16 16'h0000
`define SRST_CYCLES 2'h2
`endif

// File: logic/ir_remote_pwm_transmitter.v
// IR remote PWM transmitter: registers, divider, carrier and data generators
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "ir_remote_regs.vh"
module ir_remote_pwm_transmitter #(
  parameter DIV_W = 15
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Clock sources, already on sys_clk domain as enables
  input wire [3:0] src_tick_i,
  input wire debug_halt_i,
  // Outputs
  output reg ir_transmit_out_o,
  output reg clear_pulse_out_o,
  output reg irq_o
);

  // Control registers
  reg debug_clock_keep_reg;
  reg [3:0] clock_divider_select_reg;
  reg [1:0] clock_source_select_reg;
  reg count_clear_reg, count_run_reg, output_invert_reg;
  reg shadow_compare_enable_reg, one_shot_select_reg, module_enable_reg;
  reg [1:0] srst_cnt_reg;
  reg [15:0] active_pulse_length_reg, data_bit_length_reg;
  reg [15:0] ap_shadow_reg, db_shadow_reg;
  reg active_length_busy_reg, bit_length_busy_reg;
  reg active_match_flag_reg, length_match_flag_reg;
  reg ap_ie_reg, db_ie_reg;
  reg [7:0] carrier_high_length_reg, carrier_period_reg;
  reg out_polarity_reg, carrier_enable_reg;
  reg [15:0] data_bit_count_reg;
  reg [7:0] carrier_count_reg;
  reg carrier_wave_reg, data_wave_reg;
  reg [DIV_W-1:0] div_cnt_reg;
  // Soft reset holds the counters for a two-cycle window
  wire soft_reset_busy = (srst_cnt_reg != 2'h0);
  // Sources arrive as same-domain enable ticks
  wire src_tick = src_tick_i[clock_source_select_reg];
  // Low-speed stops at 1/256 and external is never divided; settings
  // without a listed ratio fall back to 1/1
  reg [3:0] div_sel;
  always @*
  begin
    div_sel = clock_divider_select_reg;
    case (clock_source_select_reg)
      2'h1:
      begin
        if (clock_divider_select_reg > 4'h8)
          div_sel = 4'h0;
      end
      2'h3:
        div_sel = 4'h0;
      default:
        div_sel = clock_divider_select_reg;
    endcase
  end
  wire [DIV_W:0] div_mask = ({{DIV_W{1'b0}}, 1'b1} << div_sel) - 1'b1;
  // Operating tick: enabled module, debug gate, divided source
  wire op_tick = module_enable_reg && src_tick &&
                 (!debug_halt_i || debug_clock_keep_reg) &&
                 ((div_cnt_reg & div_mask[DIV_W-1:0]) == {DIV_W{1'b0}});
  wire run_tick = op_tick && count_run_reg && !soft_reset_busy;
  // Compare sources
  wire [15:0] ap_cmp = shadow_compare_enable_reg ? ap_shadow_reg :
                       active_pulse_length_reg;
  wire [15:0] db_cmp = shadow_compare_enable_reg ? db_shadow_reg :
                       data_bit_length_reg;
  wire ap_hit = run_tick && (data_bit_count_reg == ap_cmp);
  wire db_hit = run_tick && (data_bit_count_reg == db_cmp);
  // Register write decodes
  wire wr_cc = wr_i && (addr_i == `ADDR_CNT_CTRL);
  wire srst_req = wr_cc && wdata_i[`CC_SRST_BIT];
  // Length writes need module enable, refused while busy
  wire wr_ap = wr_i && (addr_i == `ADDR_ACTIVE_LEN) && module_enable_reg &&
               !(shadow_compare_enable_reg && active_length_busy_reg);
  wire wr_db = wr_i && (addr_i == `ADDR_BIT_LEN) && module_enable_reg &&
               !(shadow_compare_enable_reg && bit_length_busy_reg);
  wire wr_st = wr_i && (addr_i == `ADDR_STATUS);

  // Source edge divider; free-running so ratio is exact
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      div_cnt_reg <= {DIV_W{1'b0}};
    else if (!module_enable_reg)
      div_cnt_reg <= {DIV_W{1'b0}};
    else if (src_tick && (!debug_halt_i || debug_clock_keep_reg))
      div_cnt_reg <= div_cnt_reg + 1'b1;
  end

  // Clock control: only accepted while module disabled
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      debug_clock_keep_reg <= 1'b0;
      clock_divider_select_reg <= 4'h0;
      clock_source_select_reg <= 2'h0;
    end
    else if (wr_i && (addr_i == `ADDR_CLK_CTRL) && !module_enable_reg)
    begin
      debug_clock_keep_reg <= wdata_i[`CLK_DBG_BIT];
      clock_divider_select_reg <= wdata_i[`CLK_DIV_HI:`CLK_DIV_LO];
      clock_source_select_reg <= wdata_i[`CLK_SRC_HI:`CLK_SRC_LO];
    end
  end

  // Counter control and soft reset sequencing
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      count_clear_reg <= 1'b0;
      count_run_reg <= 1'b0;
      output_invert_reg <= 1'b0;
      shadow_compare_enable_reg <= 1'b0;
      one_shot_select_reg <= 1'b0;
      module_enable_reg <= 1'b0;
      srst_cnt_reg <= 2'h0;
    end
    else
    begin
      if (soft_reset_busy)
        srst_cnt_reg <= srst_cnt_reg - 2'h1;
      if (wr_cc)
      begin
        output_invert_reg <= wdata_i[`CC_INV_BIT];
        shadow_compare_enable_reg <= wdata_i[`CC_BUF_BIT];
        one_shot_select_reg <= wdata_i[`CC_ONE_BIT];
        module_enable_reg <= wdata_i[`CC_EN_BIT];
        count_run_reg <= wdata_i[`CC_RUN_BIT] && wdata_i[`CC_EN_BIT];
        count_clear_reg <= wdata_i[`CC_CLR_BIT] && wdata_i[`CC_EN_BIT];
      end
      else if (count_clear_reg && op_tick)
        count_clear_reg <= 1'b0; // Clear done on next operating tick
      if (db_hit && one_shot_select_reg && !wr_cc)
        count_run_reg <= 1'b0;
      if (srst_req)
      begin
        count_clear_reg <= 1'b0;
        count_run_reg <= 1'b0;
        srst_cnt_reg <= `SRST_CYCLES;
      end
    end
  end

  // Length registers, shadows and busy flags
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      active_pulse_length_reg <= `RESET_VAL16;
      data_bit_length_reg <= `RESET_VAL16;
      ap_shadow_reg <= `RESET_VAL16;
      db_shadow_reg <= `RESET_VAL16;
      active_length_busy_reg <= 1'b0;
      bit_length_busy_reg <= 1'b0;
    end
    else
    begin
      if (wr_ap)
        active_pulse_length_reg <= wdata_i;
      if (wr_db)
        data_bit_length_reg <= wdata_i;
      if (!shadow_compare_enable_reg)
      begin
        // Shadows track registers so enabling buffering starts coherent
        ap_shadow_reg <= active_pulse_length_reg;
        db_shadow_reg <= data_bit_length_reg;
        active_length_busy_reg <= 1'b0;
        bit_length_busy_reg <= 1'b0;
      end
      else
      begin
        if (db_hit)
        begin
          ap_shadow_reg <= active_pulse_length_reg;
          db_shadow_reg <= data_bit_length_reg;
          active_length_busy_reg <= 1'b0;
          bit_length_busy_reg <= 1'b0;
        end
        if (wr_ap)
          active_length_busy_reg <= 1'b1;
        if (wr_db)
          bit_length_busy_reg <= 1'b1;
      end
    end
  end

  // Counters and waveforms
  always @(posedge sys_clk_i)
  begin
    if (rst_i || soft_reset_busy || (count_clear_reg && op_tick))
    begin
      data_bit_count_reg <= `RESET_VAL16;
      carrier_count_reg <= 8'h00;
      carrier_wave_reg <= 1'b1;
      data_wave_reg <= 1'b1;
    end
    else if (run_tick)
    begin
      // Carrier generator
      if (carrier_count_reg == carrier_period_reg)
      begin
        carrier_count_reg <= 8'h00;
        carrier_wave_reg <= 1'b1;
      end
      else
      begin
        carrier_count_reg <= carrier_count_reg + 8'h01;
        if (carrier_count_reg == carrier_high_length_reg)
          carrier_wave_reg <= 1'b0;
      end
      // Data generator
      if (db_hit)
      begin
        data_bit_count_reg <= `RESET_VAL16;
        data_wave_reg <= 1'b1;
      end
      else
      begin
        data_bit_count_reg <= data_bit_count_reg + 16'h0001;
        if (ap_hit)
          data_wave_reg <= 1'b0;
      end
    end
  end

  // Match flags: set beats clear
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      active_match_flag_reg <= 1'b0;
      length_match_flag_reg <= 1'b0;
    end
    // Soft reset clears both flags even against a fresh match
    else if (srst_req || soft_reset_busy)
    begin
      active_match_flag_reg <= 1'b0;
      length_match_flag_reg <= 1'b0;
    end
    else
    begin
      active_match_flag_reg <= ap_hit || (active_match_flag_reg &&
                               !(wr_st && wdata_i[`ST_APF_BIT]));
      length_match_flag_reg <= db_hit || (length_match_flag_reg &&
                               !(wr_st && wdata_i[`ST_DBF_BIT]));
    end
  end

  // Interrupt enable, carrier and modulation control registers
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ap_ie_reg <= 1'b0;
      db_ie_reg <= 1'b0;
      carrier_high_length_reg <= 8'h00;
      carrier_period_reg <= 8'h00;
      out_polarity_reg <= 1'b0;
      carrier_enable_reg <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == `ADDR_INTEN)
      begin
        ap_ie_reg <= wdata_i[0];
        db_ie_reg <= wdata_i[1];
      end
      if (addr_i == `ADDR_CARR)
      begin
        carrier_high_length_reg <= wdata_i[15:8];
        carrier_period_reg <= wdata_i[7:0];
      end
      if (addr_i == `ADDR_CCTL)
      begin
        out_polarity_reg <= wdata_i[`CCTL_OINV_BIT];
        carrier_enable_reg <= wdata_i[`CCTL_CAR_BIT];
      end
    end
  end

  // Registered outputs; while stopped clear pulse idles low and transmit shows the polarity bit
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ir_transmit_out_o <= 1'b0;
      clear_pulse_out_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      ir_transmit_out_o <= (count_run_reg &&
        ((carrier_wave_reg || !carrier_enable_reg) &&
         (data_wave_reg ^ output_invert_reg))) ^ out_polarity_reg;
      clear_pulse_out_o <= count_run_reg && !data_wave_reg;
      irq_o <= (active_match_flag_reg && ap_ie_reg) ||
               (length_match_flag_reg && db_ie_reg);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      case (addr_i)
        `ADDR_CLK_CTRL: rdata_o <= {7'h00, debug_clock_keep_reg,
          clock_divider_select_reg, 2'h0, clock_source_select_reg};
        `ADDR_CNT_CTRL: rdata_o <= {6'h00, count_clear_reg, count_run_reg,
          3'h0, output_invert_reg, shadow_compare_enable_reg,
          one_shot_select_reg, soft_reset_busy, module_enable_reg};
        `ADDR_BIT_COUNT: rdata_o <= data_bit_count_reg;
        `ADDR_ACTIVE_LEN: rdata_o <= active_pulse_length_reg;
        `ADDR_BIT_LEN: rdata_o <= data_bit_length_reg;
        `ADDR_STATUS: rdata_o <= {5'h00, count_run_reg,
          bit_length_busy_reg, active_length_busy_reg, 6'h00,
          length_match_flag_reg, active_match_flag_reg};
        `ADDR_INTEN: rdata_o <= {14'h0000, db_ie_reg, ap_ie_reg};
        `ADDR_CARR: rdata_o <= {carrier_high_length_reg, carrier_period_reg};
        `ADDR_CCTL: rdata_o <= {7'h00, out_polarity_reg, 7'h00,
          carrier_enable_reg};
        default: rdata_o <= 16'h0000;
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end

endmodule

// File: test/ir_receiver_model.sv
// Receiver model: measures high runs on the transmit and clear lines
`timescale 1ns/1ps
module ir_receiver_model (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Lines from the transmitter
  input wire tx_i,
  input wire clr_i,
  // Measurements
  output reg [15:0] tx_width_o,
  output reg [15:0] clr_width_o,
  output reg [7:0] tx_pulses_o
);
  reg [15:0] tx_run_reg;
  reg [15:0] clr_run_reg;
  reg [7:0] pulse_cnt_reg;
  // Widths latch on the fall; pulses before a clear pulse are counted
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_run_reg <= 16'h0000;
      clr_run_reg <= 16'h0000;
      pulse_cnt_reg <= 8'h00;
      tx_width_o <= 16'h0000;
      clr_width_o <= 16'h0000;
      tx_pulses_o <= 8'h00;
    end
    else
    begin
      tx_run_reg <= tx_i ? tx_run_reg + 16'h0001 : 16'h0000;
      clr_run_reg <= clr_i ? clr_run_reg + 16'h0001 : 16'h0000;
      if (!tx_i && tx_run_reg != 16'h0000)
        tx_width_o <= tx_run_reg;
      if (!clr_i && clr_run_reg != 16'h0000)
        clr_width_o <= clr_run_reg;
      if (clr_i && clr_run_reg == 16'h0000)
      begin
        tx_pulses_o <= pulse_cnt_reg;
        pulse_cnt_reg <= 8'h00;
      end
      else if (tx_i && tx_run_reg == 16'h0000)
        pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
    end
  end
endmodule

// File: test/ir_remote_pwm_transmitter_assertions.sv
// Port-level checks for the IR transmitter
`timescale 1ns/1ps
`include "ir_remote_regs.vh"
module ir_tx_checker #(
  parameter DIV_W = 15
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // Ticks and outputs
  input wire [3:0] src_tick_i,
  input wire ir_transmit_out_o,
  input wire clear_pulse_out_o,
  input wire irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Control writes that must silence both outputs
  wire cc_wr = wr_i && addr_i == `ADDR_CNT_CTRL && !wdata_i[`CC_INV_BIT];
  wire lines_low = !ir_transmit_out_o && !clear_pulse_out_o;
  chk_rdata_idle_zero:
    assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside answer cycle");
  chk_unmapped_read_zero:
    assert property ($past(rd_i) && $past(addr_i) > `ADDR_CCTL
      |-> rdata_o == 16'h0000) else $error("unmapped read not zero");
  chk_clk_reserved_zero:
    assert property ($past(rd_i) && $past(addr_i) == `ADDR_CLK_CTRL
      |-> rdata_o[15:9] == 7'h00 && rdata_o[3:2] == 2'h0)
    else $error("clock control reserved bits set");
  chk_status_reserved_zero:
    assert property ($past(rd_i) && $past(addr_i) == `ADDR_STATUS
      |-> rdata_o[15:11] == 5'h00 && rdata_o[7:2] == 6'h00)
    else $error("status reserved bits set");
  chk_irq_masked_off:
    assert property (wr_i && addr_i == `ADDR_INTEN && wdata_i[1:0] == 2'h0
      |-> ##2 !irq_o) else $error("interrupt with all enables off");
  chk_no_tick_frozen:
    assert property ((!wr_i && src_tick_i == 4'h0) [*6]
      |-> $stable(ir_transmit_out_o) && $stable(clear_pulse_out_o))
    else $error("outputs moved without operating tick");
  chk_soft_reset_quiet:
    assert property (cc_wr && wdata_i[`CC_SRST_BIT] |-> ##[1:3] lines_low)
    else $error("outputs active after soft reset");
  chk_stop_quiet:
    assert property (cc_wr && !wdata_i[`CC_RUN_BIT] |-> ##[1:3] lines_low)
    else $error("outputs active after run cleared");
endmodule
bind ir_remote_pwm_transmitter ir_tx_checker #(.DIV_W(DIV_W)) u_ir_tx_checker (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_tick_i(src_tick_i),
  .ir_transmit_out_o(ir_transmit_out_o),
  .clear_pulse_out_o(clear_pulse_out_o), .irq_o(irq_o));

// File: test/ir_remote_pwm_transmitter_test.sv
// Self-checking bench for the IR transmitter
`timescale 1ns/1ps
`include "ir_remote_regs.vh"
module ir_remote_pwm_transmitter_test;
  reg sys_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] addr_i = 4'h0;
  reg [15:0] wdata_i = 16'h0000;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [3:0] src_tick_i = 4'h1;
  reg debug_halt_i = 1'b0;
  wire [15:0] rdata_o;
  wire ir_transmit_out_o;
  wire clear_pulse_out_o;
  wire irq_o;
  wire [15:0] tx_width;
  wire [15:0] clr_width;
  wire [7:0] tx_pulses;
  reg rd_d = 1'b0;
  reg pause = 1'b0;
  reg [31:0] exp_q [$];
  reg [31:0] exp_e;
  reg [31:0] ran;
  reg [31:0] rv;
  reg [15:0] ap;
  reg [15:0] db;
  integer err_total = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  ir_remote_pwm_transmitter #(.DIV_W(15)) u_ir_remote_pwm_transmitter (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .src_tick_i(src_tick_i), .debug_halt_i(debug_halt_i),
    .ir_transmit_out_o(ir_transmit_out_o),
    .clear_pulse_out_o(clear_pulse_out_o), .irq_o(irq_o));
  ir_receiver_model u_ir_receiver_model (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .tx_i(ir_transmit_out_o),
    .clr_i(clear_pulse_out_o), .tx_width_o(tx_width),
    .clr_width_o(clr_width), .tx_pulses_o(tx_pulses));
  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task end_of_test;
  begin
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task check(input string n, input [15:0] seen, input [15:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("wrong value %0s expected %h seen %h", n, exp, seen);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    if (wr_i) @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  end
  endtask
  // A read notes its masked expectation; the monitor compares it
  task rd(input [3:0] a, input [15:0] m, input [15:0] e);
  begin
    if (rd_i) @(posedge sys_clk_i);
    exp_q.push_back({m, e});
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  end
  endtask
  // Debug halt toggles at random; keep bit is set so counting must go on
  always @(posedge sys_clk_i)
  begin
    ran = $urandom;
    debug_halt_i <= ran[0];
    src_tick_i <= pause ? 4'h0 : {ran[3:1], 1'b1};
    rd_d <= rd_i;
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  // Read data stand only in the cycle after the strobe
  always @(negedge sys_clk_i)
  begin
    if (rd_d)
    begin
      exp_e = exp_q.pop_front();
      check("rdata", rdata_o & exp_e[31:16], exp_e[15:0]);
    end
  end
  // One-shot frame from a clean soft reset, then far-side measurements
  task shot(input [15:0] a, input [15:0] d, input [15:0] cc,
    input [15:0] w, input [15:0] c, input [7:0] p);
  begin
    wr(`ADDR_CNT_CTRL, 16'h0003);
    wr(`ADDR_ACTIVE_LEN, a);
    wr(`ADDR_BIT_LEN, d);
    wr(`ADDR_CCTL, cc);
    wr(`ADDR_CNT_CTRL, 16'h0105);
    repeat (d + 12) @(posedge sys_clk_i);
    check("tx width", tx_width, w);
    check("clear width", clr_width, c);
    check("pulses", {8'h00, tx_pulses}, {8'h00, p});
    check("irq", {15'h0000, irq_o}, 16'h0001);
    rd(`ADDR_STATUS, 16'hffff, 16'h0003);
  end
  endtask
  initial
  begin
    rv = $urandom(32'ha7727e0f);
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(`ADDR_CLK_CTRL, 16'hffff, 16'h0000);
    rd(`ADDR_CNT_CTRL, 16'hffff, 16'h0000);
    wr(`ADDR_CLK_CTRL, 16'h0100);
    wr(`ADDR_CNT_CTRL, 16'h0001);
    wr(`ADDR_CLK_CTRL, 16'h0000);
    rd(`ADDR_CLK_CTRL, 16'hffff, 16'h0100);
    wr(`ADDR_INTEN, 16'h0003);
    wr(`ADDR_CNT_CTRL, 16'h0003);
    rd(`ADDR_CNT_CTRL, 16'h0002, 16'h0002);
    repeat (4) @(posedge sys_clk_i);
    rd(`ADDR_CNT_CTRL, 16'hffff, 16'h0001);
    // Carrier: high 2 of 4 ticks inside an 8 tick data high
    wr(`ADDR_CARR, 16'h0103);
    shot(16'h0007, 16'h0009, 16'h0001, 16'h0002, 16'h0002, 8'h02);
    for (i = 0; i < 4; i = i + 1)
    begin
      rv = $urandom;
      db = 16'h0002 + {11'h000, rv[4:0]};
      ap = {11'h000, rv[20:16]} % db;
      shot(ap, db, 16'h0000, ap + 16'h0001, db - ap, 8'h01);
    end
    wr(`ADDR_STATUS, 16'h0001);
    rd(`ADDR_STATUS, 16'h0003, 16'h0002);
    wr(`ADDR_INTEN, 16'h0001);
    repeat (3) @(posedge sys_clk_i);
    check("irq", {15'h0000, irq_o}, 16'h0000);
    wr(`ADDR_INTEN, 16'h0002);
    repeat (3) @(posedge sys_clk_i);
    check("irq", {15'h0000, irq_o}, 16'h0001);
    wr(`ADDR_STATUS, 16'h0002);
    rd(`ADDR_STATUS, 16'h0003, 16'h0000);
    wr(`ADDR_CNT_CTRL, 16'h0000);
    wr(`ADDR_ACTIVE_LEN, 16'h0005);
    rd(`ADDR_ACTIVE_LEN, 16'hffff, ap);
    // Shadowed repeat run: a staged length waits for the period end
    wr(`ADDR_CNT_CTRL, 16'h0003);
    wr(`ADDR_ACTIVE_LEN, 16'h0003);
    wr(`ADDR_BIT_LEN, 16'h0009);
    wr(`ADDR_CNT_CTRL, 16'h0109);
    wr(`ADDR_ACTIVE_LEN, 16'h0005);
    rd(`ADDR_STATUS, 16'h0100, 16'h0100);
    wr(`ADDR_ACTIVE_LEN, 16'h0001);
    pause <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    pause <= 1'b0;
    repeat (30) @(posedge sys_clk_i);
    rd(`ADDR_ACTIVE_LEN, 16'hffff, 16'h0005);
    rd(`ADDR_STATUS, 16'h0500, 16'h0400);
    check("tx width", tx_width, 16'h0006);
    // Flags stay set but both enables off: request must drop
    wr(`ADDR_INTEN, 16'h0000);
    repeat (3) @(posedge sys_clk_i);
    check("irq", {15'h0000, irq_o}, 16'h0000);
    wr(`ADDR_CNT_CTRL, 16'h0001);
    // Stopped output shows only the polarity bit
    wr(`ADDR_CCTL, 16'h0100);
    repeat (3) @(posedge sys_clk_i);
    check("tx idle", {15'h0000, ir_transmit_out_o}, 16'h0001);
    wr(`ADDR_CCTL, 16'h0000);
    wr(`ADDR_CNT_CTRL, 16'h0000);
    repeat (4) @(posedge sys_clk_i);
    end_of_test;
  end
endmodule
